// *** rtf_defines.svh ***
// Purpose: constants of the telegram framer host
// Assumes: byte-wide character link, one clock
// Notes:   offsets index the host's own command registers
`ifndef RTF_DEFINES_SVH
`define RTF_DEFINES_SVH
`define RTF_EOT          8'h04
`define RTF_STX          8'h02
`define RTF_ETX          8'h03
`define RTF_ENQ          8'h05
`define RTF_ACK          8'h06
`define RTF_NAK          8'h15
`define RTF_EQ           8'h3D
`define RTF_DIG4         8'h34
`define RTF_DIG9         8'h39
`define RTF_MAX_DATA     7'h50
`define RTF_STAT_FIXED   8'h30
`define RTF_STAT_MASK    8'hF2
`define RTF_STAT_CALLUP  0
`define RTF_STAT_MULTI   2
`define RTF_STAT_ACKREQ  3
`define RTF_A_CTRL       4'h0
`define RTF_A_ADDR       4'h1
`define RTF_A_LEN        4'h2
`define RTF_A_TXDATA     4'h3
`define RTF_A_STATUS     4'h4
`define RTF_A_IRQ        4'h5
`define RTF_A_MASK       4'h6
`define RTF_A_RXDATA     4'h7
`define RTF_A_RXLEN      4'h8
`define RTF_IRQ_DONE     0
`define RTF_IRQ_NAK      1
`define RTF_IRQ_BCC      2
`define RTF_IRQ_FRAME    3
`endif

// *** rtf_pkg.sv ***
// Purpose: types of the telegram framer host
// Assumes: nothing beyond the defines header
// Notes:   none
package rtf_pkg;
	typedef enum logic [1:0] {RTF_OP_NONE, RTF_OP_SELECT, RTF_OP_ENQUIRY} rtf_op_e;
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} rtf_cmd_s;
	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} rtf_byte_s;
endpackage

// *** rtf_host.sv ***
// Purpose: master side of the select/enquiry telegram link
// Assumes: a UART outside moves the bytes; tx_ready is a level
// Notes:   the status byte is the first use-data byte written by software
//
// Summary of operation
// - every telegram carries the parameter code 49999 as five ascii digits.
// - an exchange opens with a select; only after that may an enquiry fetch the reply.
// - after a nak the master queries the cause with the error_cause_query command in a new select; this host only raises the nak event and status bit 3.
// - a select is eot, address, stx, 49999, '=', 0 to 80 use bytes, etx, bcc.
// - an enquiry is eot, address, 49999, enq, with no stx, data or bcc.
// - use data of select and reply starts with one status byte.
// - status bit 0 set is a call-up telegram, clear a data telegram acknowledged only.
// - status bit 2 set means more blocks follow, clear a single or final block.
// - status bit 3 set requests an acknowledge.
// - status bit 1 is zero, bits 4 and 5 one, bits 6 and 7 zero.
// - after a select the device answers address and ack or nak, then the master sends eot.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`include "rtf_defines.svh"
module rtf_host
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire rtf_pkg::rtf_cmd_s cmd,
	output      logic [7:0]    rdata,
	output      logic          irq,
	output      logic [7:0]    tx_data,
	output      logic          tx_valid,
	input  wire logic          tx_ready,
	input  wire rtf_pkg::rtf_byte_s rx
);
	import rtf_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {S_IDLE, S_TX, S_WAIT_ACK, S_WAIT_REPLY, S_EOT} rtf_state_e;
	rtf_state_e  state;
	rtf_op_e     op;
	logic [7:0]  station;
	logic [6:0]  tx_len;
	logic [7:0]  tx_mem [0:79];
	logic [7:0]  rx_mem [0:79];
	logic [6:0]  wr_ptr;
	logic [6:0]  rd_ptr;
	logic [6:0]  rx_len;
	logic [6:0]  idx;
	logic [7:0]  bcc;
	logic [3:0]  rx_phase;
	logic        selected;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_mask;
	logic        last_nak;

	// tx position: 0 eot,1 adr,2 stx,3..7 code,8 '=',9.. data,etx,bcc
	function automatic logic [7:0] code_digit(input logic [6:0] pos);
		code_digit = (pos == 7'h03) ? `RTF_DIG4 : `RTF_DIG9;
	endfunction

	wire is_wr     = cmd.wr;
	wire go_sel    = is_wr && cmd.addr == `RTF_A_CTRL && cmd.wdata[0];
	wire go_enq    = is_wr && cmd.addr == `RTF_A_CTRL && cmd.wdata[1] && selected;
	wire idle      = state == S_IDLE;
	wire tx_fire   = tx_valid && tx_ready;
	wire [6:0] data_end = 7'h09 + tx_len;
	// status byte fixed bits are forced so software cannot break them
	wire [7:0] stat_fix = (tx_mem[0] & ~`RTF_STAT_MASK) | `RTF_STAT_FIXED;
	wire [7:0] sel_byte =
		(idx == 7'h00) ? `RTF_EOT :
		(idx == 7'h01) ? station :
		(idx == 7'h02) ? `RTF_STX :
		(idx <= 7'h07) ? code_digit(idx) :
		(idx == 7'h08) ? `RTF_EQ :
		(idx == 7'h09 && tx_len != 7'h00) ? stat_fix :
		(idx < data_end) ? tx_mem[idx - 7'h09] :
		(idx == data_end) ? `RTF_ETX : bcc;
	wire [7:0] enq_byte =
		(idx == 7'h00) ? `RTF_EOT :
		(idx == 7'h01) ? station :
		(idx <= 7'h06) ? code_digit(idx + 7'h01) : `RTF_ENQ;
	wire [7:0] next_byte = (op == RTF_OP_SELECT) ? sel_byte : enq_byte;
	wire [6:0] stop_idx  = (op == RTF_OP_SELECT) ? data_end + 7'h02 : 7'h08; // idx runs one ahead of tx_data
	wire       ack_req   = tx_len == 7'h00 || tx_mem[0][`RTF_STAT_ACKREQ];
	wire [3:0] irq_clr   = (is_wr && cmd.addr == `RTF_A_IRQ) ? cmd.wdata[3:0] : 4'h0;
	logic [3:0] ev;

	////////////////////////////////////////////////////////////////////////////
	// register writes and rx read pointer
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			station  <= 8'h00;
			tx_len   <= 7'h00;
			wr_ptr   <= 7'h00;
			irq_mask <= 4'h0;
			rd_ptr   <= 7'h00;
		end
		else
		begin
			if (is_wr && cmd.addr == `RTF_A_ADDR)
				station <= cmd.wdata;
			if (is_wr && cmd.addr == `RTF_A_LEN && idle)
			begin
				tx_len <= (cmd.wdata[6:0] > `RTF_MAX_DATA) ? `RTF_MAX_DATA : cmd.wdata[6:0];
				wr_ptr <= 7'h00;
			end
			if (is_wr && cmd.addr == `RTF_A_TXDATA && idle && wr_ptr < `RTF_MAX_DATA)
			begin
				tx_mem[wr_ptr] <= cmd.wdata;
				wr_ptr <= wr_ptr + 7'h01;
			end
			if (is_wr && cmd.addr == `RTF_A_MASK)
				irq_mask <= cmd.wdata[3:0];
			if (cmd.rd && cmd.addr == `RTF_A_RXDATA && rd_ptr < rx_len)
				rd_ptr <= rd_ptr + 7'h01;
			else if (rx_phase == 4'h1)
				rd_ptr <= 7'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// telegram sequencer
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state    <= S_IDLE;
			op       <= RTF_OP_NONE;
			idx      <= 7'h00;
			bcc      <= 8'h00;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			rx_phase <= 4'h0;
			rx_len   <= 7'h00;
			selected <= 1'b0;
			last_nak <= 1'b0;
			ev       <= 4'h0;
		end
		else
		begin
			ev <= 4'h0;
			case (state)
				S_IDLE:
				begin
					if (go_sel || go_enq)
					begin
						op       <= go_sel ? RTF_OP_SELECT : RTF_OP_ENQUIRY;
						idx      <= 7'h00;
						bcc      <= 8'h00;
						state    <= S_TX;
					end
				end
				S_TX:
				begin
					if (!tx_valid || tx_fire)
					begin
						if (tx_fire && idx == stop_idx)
						begin
							tx_valid <= 1'b0;
							rx_phase <= 4'h0;
							state    <= (op == RTF_OP_SELECT) ? (ack_req ? S_WAIT_ACK : S_EOT) : S_WAIT_REPLY;
						end
						else
						begin
							tx_data  <= next_byte;
							tx_valid <= 1'b1;
							if (idx >= 7'h03 && idx <= data_end && op == RTF_OP_SELECT)
								bcc <= bcc ^ next_byte;
							idx <= idx + 7'h01;
						end
					end
				end
				S_WAIT_ACK:
				begin
					// address byte, then ack or nak
					if (rx.valid)
					begin
						if (rx_phase == 4'h0)
							rx_phase <= (rx.data == station) ? 4'h1 : 4'h0;
						else
						begin
							last_nak <= rx.data == `RTF_NAK;
							selected <= rx.data == `RTF_ACK;
							ev[`RTF_IRQ_NAK]  <= rx.data == `RTF_NAK;
							ev[`RTF_IRQ_DONE] <= rx.data == `RTF_ACK;
							state <= S_EOT;
						end
					end
				end
				S_WAIT_REPLY:
				begin
					// 0 adr,1 stx,2..6 code,7 '=',8 data..etx,9 bcc
					if (rx.valid)
					begin
						rx_phase <= rx_phase + 4'h1;
						case (rx_phase)
							4'h0: rx_phase <= (rx.data == station) ? 4'h1 : 4'h0;
							4'h1:
							begin
								bcc    <= 8'h00;
								rx_len <= 7'h00;
								if (rx.data != `RTF_STX)
								begin
									ev[`RTF_IRQ_FRAME] <= 1'b1;
									state <= S_EOT;
								end
							end
							4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
							begin
								bcc <= bcc ^ rx.data;
								if (rx.data != ((rx_phase == 4'h7) ? `RTF_EQ :
									code_digit({3'h0, rx_phase} + 7'h01)))
								begin
									ev[`RTF_IRQ_FRAME] <= 1'b1;
									state <= S_EOT;
								end
							end
							4'h8:
							begin
								rx_phase <= 4'h8;
								bcc <= bcc ^ rx.data;
								if (rx.data == `RTF_ETX)
									rx_phase <= 4'h9;
								else if (rx_len < `RTF_MAX_DATA)
								begin
									rx_mem[rx_len] <= rx.data;
									rx_len <= rx_len + 7'h01;
								end
								else
								begin
									ev[`RTF_IRQ_FRAME] <= 1'b1;
									state <= S_EOT;
								end
							end
							default:
							begin
								ev[`RTF_IRQ_BCC]  <= rx.data != bcc;
								ev[`RTF_IRQ_DONE] <= rx.data == bcc;
								state <= S_EOT;
							end
						endcase
					end
				end
				S_EOT:
				begin
					// closing eot ends the exchange
					if (!tx_valid)
					begin
						tx_data  <= `RTF_EOT;
						tx_valid <= 1'b1;
					end
					else if (tx_ready)
					begin
						tx_valid <= 1'b0;
						state    <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts and read data; a new event beats a same-cycle clear
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_stat <= 4'h0;
			irq      <= 1'b0;
			rdata    <= 8'h00;
		end
		else
		begin
			irq_stat <= (irq_stat & ~irq_clr) | ev;
			irq      <= |(((irq_stat & ~irq_clr) | ev) & irq_mask);
			case (cmd.addr)
				`RTF_A_ADDR:   rdata <= station;
				`RTF_A_LEN:    rdata <= {1'b0, tx_len};
				`RTF_A_STATUS: rdata <= {4'h0, last_nak, selected, (state != S_IDLE), 1'b0};
				`RTF_A_IRQ:    rdata <= {4'h0, irq_stat};
				`RTF_A_MASK:   rdata <= {4'h0, irq_mask};
				`RTF_A_RXDATA: rdata <= (rd_ptr < rx_len) ? rx_mem[rd_ptr] : 8'h00;
				`RTF_A_RXLEN:  rdata <= {1'b0, rx_len};
				default:       rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_eot_first;
		@(posedge clock) disable iff (sys_rst)
		$rose(state == S_TX) |=> tx_valid && tx_data == `RTF_EOT;
	endproperty
	a_eot_first: assert property (p_eot_first) else $error("telegram not opened by eot");
	property p_enq_needs_sel;
		@(posedge clock) disable iff (sys_rst)
		state == S_TX && op == RTF_OP_ENQUIRY |-> selected;
	endproperty
	a_enq_needs_sel: assert property (p_enq_needs_sel) else $error("enquiry without select");
	property p_stat_fixed;
		@(posedge clock) disable iff (sys_rst)
		op == RTF_OP_SELECT && tx_fire && idx == 7'h0A && tx_len != 7'h00
			|-> (tx_data & `RTF_STAT_MASK) == `RTF_STAT_FIXED;
	endproperty
	a_stat_fixed: assert property (p_stat_fixed) else $error("status byte fixed bits wrong");
	property p_eot_close;
		@(posedge clock) disable iff (sys_rst)
		state == S_WAIT_ACK && rx.valid && rx_phase == 4'h1 |=> ##1 tx_valid && tx_data == `RTF_EOT;
	endproperty
	a_eot_close: assert property (p_eot_close) else $error("no closing eot");
	property p_enq_code;
		@(posedge clock) disable iff (sys_rst)
		op == RTF_OP_ENQUIRY && state == S_TX && tx_fire && idx == 7'h08 |-> tx_data == `RTF_ENQ;
	endproperty
	a_enq_code: assert property (p_enq_code) else $error("enquiry not closed by enq");
	property p_code_digit;
		@(posedge clock) disable iff (sys_rst)
		op == RTF_OP_SELECT && state == S_TX && tx_fire && idx == 7'h04 |-> tx_data == `RTF_DIG4;
	endproperty
	a_code_digit: assert property (p_code_digit) else $error("code does not start with 4");
	property p_len_cap;
		@(posedge clock) disable iff (sys_rst)
		tx_len <= `RTF_MAX_DATA && rx_len <= `RTF_MAX_DATA;
	endproperty
	a_len_cap: assert property (p_len_cap) else $error("use data over 80 bytes");
	property p_irq_level;
		@(posedge clock) disable iff (sys_rst)
		irq |-> $past(|((irq_stat & ~irq_clr | ev) & irq_mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq without cause");
	c_select: cover property (@(posedge clock) disable iff (sys_rst) ev[`RTF_IRQ_DONE] && op == RTF_OP_SELECT);
	c_enquiry: cover property (@(posedge clock) disable iff (sys_rst) ev[`RTF_IRQ_DONE] && op == RTF_OP_ENQUIRY);
	c_nak: cover property (@(posedge clock) disable iff (sys_rst) ev[`RTF_IRQ_NAK]);
endmodule

// *** rtf_dev_model.sv ***
// Purpose: behavioural model of the drive station on the telegram link
// Assumes: one byte accepted per tx_valid and tx_ready edge
// Notes:   tx_ready stalls every other cycle; rx data toggles while idle
`include "rtf_defines.svh"
module rtf_dev_model
(
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic [7:0]         tx_data,
	input  wire logic               tx_valid,
	output      logic               tx_ready,
	output      rtf_pkg::rtf_byte_s rx,
	input  wire logic               nak,
	input  wire logic               bad_bcc
);
	timeunit 1ns;
	timeprecision 1ps;
	import rtf_pkg::*;
	logic [7:0] got[$];
	logic [7:0] rq[$];
	logic [7:0] rep[15];
	logic [7:0] last, adr, cs;
	logic       in_d, etx_seen, ph;
	int         k;
	////////////////////////////////////////////////////////////////////////
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_ready <= 1'b0;
			rx <= '0;
			ph <= 1'b0;
			in_d = 1'b0;
			etx_seen = 1'b0;
			last = 8'h00;
		end
		else
		begin
			ph <= ~ph;
			tx_ready <= ph;
			if (tx_valid && tx_ready)
			begin
				got.push_back(tx_data);
				if (last == `RTF_EOT) adr = tx_data;
				if (etx_seen)
				begin
					// answer address then ack or nak; bcc covers bytes after stx
					rq.push_back(adr);
					rq.push_back((tx_data == cs && !nak) ? `RTF_ACK : `RTF_NAK);
					etx_seen = 1'b0;
					in_d = 1'b0;
				end
				else if (tx_data == `RTF_ENQ && !in_d)
				begin
					// reply: status byte, actual position G0, then limit field P1
					rep = '{adr, `RTF_STX, 8'h34, 8'h39, 8'h39, 8'h39, 8'h39, `RTF_EQ, 8'h30,
						8'h47, 8'h30, 8'h50, 8'h31, `RTF_ETX, 8'h00};
					for (k = 2; k < 14; k++) rep[14] ^= rep[k];
					rep[14] ^= {8{bad_bcc}};
					for (k = 0; k < 15; k++) rq.push_back(rep[k]);
				end
				else if (in_d)
				begin
					cs ^= tx_data;
					if (tx_data == `RTF_ETX) etx_seen = 1'b1;
				end
				if (tx_data == `RTF_STX && !in_d)
				begin
					in_d = 1'b1;
					cs = 8'h00;
				end
				last = tx_data;
			end
			// idle line shows the inverse so a stale value is never mistaken for data
			if (rq.size() > 0 && !rx.valid) rx <= '{1'b1, rq.pop_front()};
			else rx <= '{1'b0, ~rx.data};
		end
	end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench of the telegram framer host
// Assumes: register offsets of the defines header
// Notes:   busy is polled through the status register between telegrams
`include "rtf_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rtf_pkg::*;
	logic       clock, sys_rst, irq, tx_valid, tx_ready, nak, bad_bcc;
	rtf_cmd_s   cmd;
	rtf_byte_s  rx;
	logic [7:0] rdata, tx_data, v;
	int         n_mismatch, cmp_count;
	rtf_host uut (.clock(clock), .sys_rst(sys_rst), .cmd(cmd), .rdata(rdata), .irq(irq),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx(rx));
	rtf_dev_model dev (.clock(clock), .sys_rst(sys_rst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx(rx), .nak(nak), .bad_bcc(bad_bcc));
	////////////////////////////////////////////////////////////////////////
	task summarize();
		if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		cmd <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		cmd <= '0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		cmd <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		cmd <= '0;
		#1 d = rdata;
	endtask
	task go(input logic [3:0] c, input logic [7:0] st);
		wr(`RTF_A_LEN, 8'h01);
		wr(`RTF_A_TXDATA, st);
		dev.got.delete();
		wr(`RTF_A_CTRL, c);
	endtask
	task wt(input int n, input logic w);
		int i;
		logic [7:0] s;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge clock);
			if (dev.got.size() >= n && (!w || irq === 1'b1)) break;
		end
		s = 8'h02;
		while (i < 3000 && s[1] !== 1'b0)
		begin
			rd(`RTF_A_STATUS, s);
			i++;
		end
		if (i >= 3000)
		begin
			n_mismatch++;
			summarize();
		end
	endtask
	task chk_frame(input logic enq, input logic [7:0] st);
		logic [7:0] e[$];
		logic [7:0] b;
		int i;
		e = '{`RTF_EOT, 8'h41};
		if (!enq) e.push_back(`RTF_STX);
		e = {e, 8'h34, 8'h39, 8'h39, 8'h39, 8'h39};
		if (enq) e.push_back(`RTF_ENQ);
		else
		begin
			e = {e, `RTF_EQ, st, `RTF_ETX};
			b = 8'h00;
			for (i = 3; i < e.size(); i++) b ^= e[i];
			e = {e, b, `RTF_EOT};
		end
		for (i = 0; i < e.size(); i++) `CHK("tx byte", e[i], dev.got[i])
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial
	begin
		sys_rst = 1'b1;
		cmd = '0;
		nak = 1'b0;
		bad_bcc = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (3) @(posedge clock);
		`CHK("reset outs", 3'b000, {irq, tx_valid, |rdata})
		sys_rst <= 1'b0;
		// status byte ff goes out as 3d: fixed bits forced
		wr(`RTF_A_MASK, 8'h0F);
		wr(`RTF_A_ADDR, 8'h41);
		go(4'h1, 8'hFF);
		wt(13, 1'b1);
		chk_frame(1'b0, 8'h3D);
		rd(`RTF_A_IRQ, v);
		`CHK("irq done", 8'h01, v)
		rd(`RTF_A_STATUS, v);
		`CHK("selected", 8'h04, v & 8'h0E)
		wr(`RTF_A_IRQ, 8'h01);
		@(posedge clock);
		`CHK("irq cleared", 1'b0, irq)
		// enquiry fetches the reply; use data pops status byte first
		dev.got.delete();
		wr(`RTF_A_CTRL, 8'h02);
		wt(8, 1'b1);
		chk_frame(1'b1, 8'h00);
		rd(`RTF_A_RXLEN, v);
		`CHK("rx len", 8'h05, v)
		rd(`RTF_A_RXDATA, v);
		`CHK("rx status", 8'h30, v)
		for (int j = 0; j < 4; j++)
		begin
			rd(`RTF_A_RXDATA, v);
			`CHK("rx data", 8'(32'h4730_5031 >> (24 - 8 * j)), v)
		end
		wr(`RTF_A_IRQ, 8'h0F);
		// refused select ends with nak and an eot
		nak <= 1'b1;
		go(4'h1, 8'h38);
		wt(13, 1'b1);
		chk_frame(1'b0, 8'h38);
		rd(`RTF_A_IRQ, v);
		`CHK("irq nak", 8'h02, v & 8'h02)
		rd(`RTF_A_STATUS, v);
		`CHK("last nak", 8'h08, v & 8'h08)
		wr(`RTF_A_IRQ, 8'h0F);
		nak <= 1'b0;
		// masked done event keeps irq low
		wr(`RTF_A_MASK, 8'h02);
		go(4'h1, 8'h38);
		wt(13, 1'b0);
		`CHK("masked irq", 1'b0, irq)
		rd(`RTF_A_IRQ, v);
		`CHK("sticky done", 8'h01, v & 8'h01)
		wr(`RTF_A_IRQ, 8'h0F);
		// corrupt reply check character raises the bcc event
		wr(`RTF_A_MASK, 8'h04);
		bad_bcc <= 1'b1;
		dev.got.delete();
		wr(`RTF_A_CTRL, 8'h02);
		wt(8, 1'b1);
		rd(`RTF_A_IRQ, v);
		`CHK("bcc error", 8'h04, v & 8'h04)
		rd(4'hF, v);
		`CHK("unmapped", 8'h00, v)
		summarize();
	end
endmodule
